/* design/fruo_cfg.svh */
// Purpose: constants for the file register unary operation unit
// Assumes: 8-bit data, 7-bit register address
// Notes:   included by the package and the unit
`ifndef FRUO_CFG_SVH
`define FRUO_CFG_SVH
`define FRUO_DATA_W      8
`define FRUO_ADDR_W      7
`define FRUO_ZERO        8'h00
`define FRUO_ONE         8'h01
`define FRUO_ALL_ONES    8'hFF
`define FRUO_ZFLAG_RST   1'b0
`define FRUO_DEST_ACC    1'b0
`define FRUO_DEST_REG    1'b1
`define FRUO_OP_W        3
`endif

/* design/fruo_pkg.sv */
// Purpose: types for the file register unary operation unit
// Assumes: fruo_cfg.svh holds the numeric constants
// Notes:   operation codes are listed here
`include "fruo_cfg.svh"
package fruo_pkg;
    typedef enum logic [`FRUO_OP_W-1:0] {
        FRUO_NONE                = 3'b000,
        FRUO_COMPLEMENT_REG      = 3'b001,
        FRUO_CLEAR_REG           = 3'b010,
        FRUO_DECREMENT_REG       = 3'b011,
        FRUO_CLEAR_ACCUMULATOR   = 3'b100,
        FRUO_DECREMENT_SKIP_ZERO = 3'b101,
        FRUO_INCREMENT_SKIP_ZERO = 3'b110
    } fruo_op_t;
endpackage

/* design/fruo_unit.sv */
// Purpose: executes the single-operand file register operations
// Assumes: file register value arrives with the request in the same cycle
// Notes:   results are registered, visible one cycle after the request
`timescale 1ns/10ps
`include "fruo_cfg.svh"
module fruo_unit
    import fruo_pkg::*;
#(
    parameter int DATA_W = `FRUO_DATA_W,
    parameter int ADDR_W = `FRUO_ADDR_W
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic              op_valid_i,
    input  wire fruo_op_t          op_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              dest_i,
    input  wire logic [DATA_W-1:0] reg_data_i,
    output logic      [DATA_W-1:0] acc_o,
    output logic                   zero_o,
    output logic                   reg_we_o,
    output logic      [ADDR_W-1:0] reg_waddr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    output logic                   skip_next_o
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // refuse widths the datapath and flag logic cannot serve
    if (DATA_W != `FRUO_DATA_W || ADDR_W != `FRUO_ADDR_W) begin
        $error("fruo_unit: only 8-bit data, 7-bit address supported");
    end

    logic [DATA_W-1:0] acc_ff;
    logic              zero_ff;
    logic              reg_we_ff;
    logic [ADDR_W-1:0] reg_waddr_ff;
    logic [DATA_W-1:0] reg_wdata_ff;
    logic              skip_ff;
    logic [DATA_W-1:0] nxt_result;
    logic              nxt_dest;
    logic              nxt_write;
    logic              fire;

    // ------------------------------------------------------------
    // result computation
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] add_one(
        input logic [DATA_W-1:0] v,
        input logic              down
    );
        logic [DATA_W-1:0] r;
        r = down ? DATA_W'(v - `FRUO_ONE) : DATA_W'(v + `FRUO_ONE);
        return r;
    endfunction

    assign fire = clk_en_i & op_valid_i;

    // operation result and its destination
    always_comb begin
        nxt_result = `FRUO_ZERO;
        nxt_dest   = dest_i;
        nxt_write  = 1'b1;
        unique case (op_i)
            FRUO_NONE: begin
                nxt_result = `FRUO_ZERO;
                nxt_write  = 1'b0;
            end
            FRUO_COMPLEMENT_REG: nxt_result = ~reg_data_i;
            FRUO_CLEAR_REG: begin
                nxt_result = `FRUO_ZERO;
                nxt_dest   = `FRUO_DEST_REG;
            end
            FRUO_DECREMENT_REG: nxt_result = add_one(reg_data_i, 1'b1);
            FRUO_CLEAR_ACCUMULATOR: begin
                nxt_result = `FRUO_ZERO;
                nxt_dest   = `FRUO_DEST_ACC;
            end
            FRUO_DECREMENT_SKIP_ZERO:
                nxt_result = add_one(reg_data_i, 1'b1);
            FRUO_INCREMENT_SKIP_ZERO:
                nxt_result = add_one(reg_data_i, 1'b0);
            default: begin
                nxt_result = `FRUO_ZERO;
                nxt_write  = 1'b0; // unused code writes nothing
            end
        endcase
    end

    // ------------------------------------------------------------
    // state updates
    // ------------------------------------------------------------
    // accumulator write
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_ff <= `FRUO_ZERO;
        end else if (fire && nxt_write &&
                     nxt_dest == `FRUO_DEST_ACC) begin
            acc_ff <= nxt_result;
        end
    end

    // zero flag: skip forms leave it alone
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_ff <= `FRUO_ZFLAG_RST;
        end else if (fire) begin
            unique case (op_i)
                FRUO_CLEAR_REG, FRUO_CLEAR_ACCUMULATOR:
                    zero_ff <= 1'b1;
                FRUO_COMPLEMENT_REG, FRUO_DECREMENT_REG:
                    zero_ff <= (nxt_result == `FRUO_ZERO);
                default: zero_ff <= zero_ff;
            endcase
        end
    end

    // register write-back port, strobe updated only on enabled cycles
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_we_ff    <= 1'b0;
            reg_waddr_ff <= '0;
            reg_wdata_ff <= `FRUO_ZERO;
        end else if (clk_en_i) begin
            reg_we_ff <= op_valid_i && nxt_write &&
                         nxt_dest == `FRUO_DEST_REG;
            if (op_valid_i) begin
                reg_waddr_ff <= reg_addr_i;
                reg_wdata_ff <= nxt_result;
            end
        end
    end

    // skip request for the following instruction
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            skip_ff <= 1'b0;
        end else if (clk_en_i) begin
            skip_ff <= op_valid_i && nxt_result == `FRUO_ZERO &&
                       (op_i == FRUO_DECREMENT_SKIP_ZERO ||
                        op_i == FRUO_INCREMENT_SKIP_ZERO);
        end
    end

    assign acc_o       = acc_ff;
    assign zero_o      = zero_ff;
    assign reg_we_o    = reg_we_ff;
    assign reg_waddr_o = reg_waddr_ff;
    assign reg_wdata_o = reg_wdata_ff;
    assign skip_next_o = skip_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    complement_result_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_COMPLEMENT_REG && dest_i
        |=> reg_we_o && reg_wdata_o == ~$past(reg_data_i))
        else $error("complement result wrong");

    dest_acc_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_DECREMENT_REG && !dest_i
        |=> !reg_we_o && acc_o == $past(reg_data_i) - `FRUO_ONE)
        else $error("accumulator destination wrong");

    waddr_follow_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire |=> reg_waddr_o == $past(reg_addr_i))
        else $error("write address wrong");

    clear_reg_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_CLEAR_REG
        |=> reg_we_o && reg_wdata_o == `FRUO_ZERO && zero_o)
        else $error("clear register wrong");

    clear_acc_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_CLEAR_ACCUMULATOR
        |=> acc_o == `FRUO_ZERO && zero_o && !reg_we_o)
        else $error("clear accumulator wrong");

    decrement_zero_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_DECREMENT_REG
        |=> zero_o == ($past(reg_data_i) == `FRUO_ONE))
        else $error("decrement zero flag wrong");

    dec_skip_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_DECREMENT_SKIP_ZERO
        |=> skip_next_o == ($past(reg_data_i) == `FRUO_ONE))
        else $error("decrement skip wrong");

    inc_skip_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_INCREMENT_SKIP_ZERO
        |=> skip_next_o == ($past(reg_data_i) == `FRUO_ALL_ONES))
        else $error("increment skip wrong");

    complement_zero_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && op_i == FRUO_COMPLEMENT_REG
        |=> zero_o == ($past(reg_data_i) == `FRUO_ALL_ONES))
        else $error("complement zero flag wrong");

    skip_keeps_zero_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && (op_i == FRUO_DECREMENT_SKIP_ZERO ||
                 op_i == FRUO_INCREMENT_SKIP_ZERO)
        |=> $stable(zero_o))
        else $error("skip form changed zero flag");

    // no-op and unused codes must touch neither destination
    idle_op_quiet_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fire && (op_i == FRUO_NONE || op_i > FRUO_INCREMENT_SKIP_ZERO)
        |=> !reg_we_o && $stable(acc_o))
        else $error("no-op changed a destination");
endmodule

/* test/fruo_unit_tb_top.sv */
// Purpose: self-checking bench for the file register unary unit
// Assumes: one request per enabled cycle, results one cycle later
// Notes:   inputs change on the falling clock edge
`timescale 1ns/10ps
module fruo_unit_tb_top;
    import fruo_pkg::*;
    // ------------------------------------------------------------
    // stimulus signals, results and counters
    // ------------------------------------------------------------
    logic       core_clk_i = 1'b0;
    logic       rst_n_i    = 1'b0;
    logic       clk_en_i   = 1'b1;
    logic       op_valid_i = 1'b0;
    fruo_op_t   op_i       = FRUO_NONE;
    logic [6:0] reg_addr_i = 7'h00;
    logic       dest_i     = 1'b0;
    logic [7:0] reg_data_i = 8'h00;
    logic [7:0] acc_o;
    logic       zero_o;
    logic       reg_we_o;
    logic [6:0] reg_waddr_o;
    logic [7:0] reg_wdata_o;
    logic       skip_next_o;
    int         bad_count  = 0;
    int         tests_run  = 0;
    // 25 MHz clock
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    // unit under test
    fruo_unit i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .reg_addr_i(reg_addr_i), .dest_i(dest_i),
        .reg_data_i(reg_data_i), .acc_o(acc_o), .zero_o(zero_o),
        .reg_we_o(reg_we_o), .reg_waddr_o(reg_waddr_o),
        .reg_wdata_o(reg_wdata_o), .skip_next_o(skip_next_o));
    // ------------------------------------------------------------
    // compare and drive helpers
    // ------------------------------------------------------------
    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    // write data only matters while the strobe is up
    task automatic chk_all(input logic [7:0] a, input logic z,
                           input logic w, input logic [7:0] d,
                           input logic s);
        chk8("acc_o", a, acc_o);
        chk1("zero_o", z, zero_o);
        chk1("reg_we_o", w, reg_we_o);
        if (w === 1'b1) begin
            chk8("reg_wdata_o", d, reg_wdata_o);
        end
        chk1("skip_next_o", s, skip_next_o);
    endtask
    // present one request, return at the next falling edge
    task automatic do_op(input fruo_op_t o, input logic [6:0] a,
                         input logic d, input logic [7:0] v);
        op_valid_i = 1'b1;
        op_i       = o;
        reg_addr_i = a;
        dest_i     = d;
        reg_data_i = v;
        @(negedge core_clk_i);
    endtask
    // one empty cycle: pulses must drop, accumulator and flag hold
    task automatic idle(input logic [7:0] a, input logic z);
        op_valid_i = 1'b0;
        @(negedge core_clk_i);
        chk_all(a, z, 1'b0, 8'h00, 1'b0);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_complement();
        do_op(FRUO_COMPLEMENT_REG, 7'h7F, 1'b0, 8'h5A);
        chk_all(8'hA5, 1'b0, 1'b0, 8'h00, 1'b0);
        do_op(FRUO_COMPLEMENT_REG, 7'h7F, 1'b1, 8'hFF);
        chk_all(8'hA5, 1'b1, 1'b1, 8'h00, 1'b0);
        chk8("reg_waddr_o", 8'h7F, {1'b0, reg_waddr_o});
        idle(8'hA5, 1'b1);
        $display("test complement done");
    endtask
    task automatic t_clear();
        do_op(FRUO_COMPLEMENT_REG, 7'h05, 1'b0, 8'h00);
        do_op(FRUO_CLEAR_REG, 7'h00, 1'b0, 8'h33);
        chk_all(8'hFF, 1'b1, 1'b1, 8'h00, 1'b0);
        chk8("reg_waddr_o", 8'h00, {1'b0, reg_waddr_o});
        do_op(FRUO_COMPLEMENT_REG, 7'h05, 1'b0, 8'h0F);
        do_op(FRUO_CLEAR_ACCUMULATOR, 7'h05, 1'b1, 8'h77);
        chk_all(8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
        idle(8'h00, 1'b1);
        $display("test clear done");
    endtask
    task automatic t_decrement();
        do_op(FRUO_DECREMENT_REG, 7'h40, 1'b0, 8'h00);
        chk_all(8'hFF, 1'b0, 1'b0, 8'h00, 1'b0);
        do_op(FRUO_DECREMENT_REG, 7'h40, 1'b1, 8'h01);
        chk_all(8'hFF, 1'b1, 1'b1, 8'h00, 1'b0);
        do_op(FRUO_DECREMENT_REG, 7'h40, 1'b0, 8'h80);
        chk_all(8'h7F, 1'b0, 1'b0, 8'h00, 1'b0);
        $display("test decrement done");
    endtask
    task automatic t_skip();
        do_op(FRUO_DECREMENT_SKIP_ZERO, 7'h12, 1'b1, 8'h01);
        chk_all(8'h7F, 1'b0, 1'b1, 8'h00, 1'b1);
        do_op(FRUO_INCREMENT_SKIP_ZERO, 7'h12, 1'b0, 8'hFF);
        chk_all(8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
        do_op(FRUO_INCREMENT_SKIP_ZERO, 7'h13, 1'b1, 8'h05);
        chk_all(8'h00, 1'b0, 1'b1, 8'h06, 1'b0);
        do_op(FRUO_CLEAR_ACCUMULATOR, 7'h13, 1'b0, 8'h00);
        do_op(FRUO_DECREMENT_SKIP_ZERO, 7'h13, 1'b0, 8'h03);
        chk_all(8'h02, 1'b1, 1'b0, 8'h00, 1'b0);
        idle(8'h02, 1'b1);
        $display("test skip done");
    endtask
    task automatic t_refuse();
        clk_en_i = 1'b0;
        do_op(FRUO_COMPLEMENT_REG, 7'h01, 1'b1, 8'h00);
        chk_all(8'h02, 1'b1, 1'b0, 8'h00, 1'b0);
        chk8("reg_waddr_o", 8'h13, {1'b0, reg_waddr_o});
        clk_en_i = 1'b1;
        do_op(FRUO_NONE, 7'h01, 1'b1, 8'h00);
        chk_all(8'h02, 1'b1, 1'b0, 8'h00, 1'b0);
        do_op(fruo_op_t'(3'h7), 7'h01, 1'b0, 8'h00);
        chk_all(8'h02, 1'b1, 1'b0, 8'h00, 1'b0);
        idle(8'h02, 1'b1);
        $display("test refuse done");
    endtask
    // reset in mid-run, then a request at the first edge after release
    task automatic t_reset();
        do_op(FRUO_COMPLEMENT_REG, 7'h11, 1'b0, 8'h0F);
        chk_all(8'hF0, 1'b0, 1'b0, 8'h00, 1'b0);
        op_valid_i = 1'b0;
        rst_n_i    = 1'b0;
        @(negedge core_clk_i);
        chk_all(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        chk8("reg_waddr_o", 8'h00, {1'b0, reg_waddr_o});
        rst_n_i = 1'b1;
        do_op(FRUO_DECREMENT_SKIP_ZERO, 7'h11, 1'b1, 8'h01);
        chk_all(8'h00, 1'b0, 1'b1, 8'h00, 1'b1);
        chk8("reg_waddr_o", 8'h11, {1'b0, reg_waddr_o});
        idle(8'h00, 1'b0);
        $display("test reset done");
    endtask
    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_n_i = 1'b1;
        chk_all(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        t_complement();
        t_clear();
        t_decrement();
        t_skip();
        t_refuse();
        t_reset();
        finish_test();
    end
    // about 30 cycles of work, so 400 cycles means a hang
    initial begin
        #(40 * 400);
        bad_count++;
        finish_test();
    end
endmodule
